// File: port_c_cfg.svh
`ifndef PORT_C_CFG_SVH
`define PORT_C_CFG_SVH

// ****************************************************************
// Port geometry
// ****************************************************************
`define PORT_WIDTH 8
`define SERIAL_LOW_PIN 3
`define SERIAL_PIN_COUNT 5
`define PIN_OSC_OUT 0
`define PIN_OSC_IN 1
`define PIN_FIRST_CHANNEL 2

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define ADDR_WIDTH 12
`define OFS_PORT_PIN_VALUE 12'h000
`define OFS_PORT_OUTPUT_LATCH 12'h004
`define OFS_PORT_DIRECTION 12'h008
`define OFS_PORT_CONFIG 12'h00c

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CFG_PIN_SELECT_BIT 0
`define RST_PORT_OUTPUT_LATCH 8'h00
`define RST_PORT_DIRECTION 8'hff
`define RST_PORT_CONFIG 8'h01
`define RST_PIN_OE 8'h00

`endif

// File: port_c_pkg.sv
`default_nettype none
package port_c_pkg;

	// Bus answer sequencing, Gray coded
	typedef enum logic [1:0] {
		bus_idle = 2'b00,
		bus_answer = 2'b01
	} bus_state_type;

	// Requests from the on-chip peripherals that share the pins
	typedef struct packed {
		logic osc_enable;
		logic ccp1_out_enable;
		logic ccp1_out;
		logic pwm1a_drive;
		logic pwm1a_value;
		logic pwm1a_hiz;
		logic ccp2_out_enable;
		logic ccp2_out;
		logic pwm2a_drive;
		logic pwm2a_value;
		logic pwm2a_hiz;
		logic [4:0] serial_drive;
		logic [4:0] serial_value;
		logic [4:0] serial_force_input;
	} periph_type;

	// Levels handed back to the peripherals
	typedef struct packed {
		logic ccp1_capture;
		logic ccp2_capture;
		logic count_clock;
		logic [4:0] serial_input;
	} periph_return_type;

	// Pin driver value and enable per pin
	typedef struct packed {
		logic [7:0] value;
		logic [7:0] enable;
	} pin_drive_type;

	// Whole state of the port
	typedef struct packed {
		bus_state_type bus_state;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] latch;
		logic [7:0] direction;
		logic [7:0] config_bits;
		logic [7:0] pin_sample;
		pin_drive_type drive;
		periph_return_type ret;
	} state_type;

endpackage : port_c_pkg
`default_nettype wire

// File: port_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_c_cfg.svh"

module port_pin_mux (
	// Port registers
	input wire logic [7:0] latch_in,
	input wire logic [7:0] direction_in,
	input wire logic pin_select_in,
	// Peripheral requests
	input wire port_c_pkg::periph_type periph_in,
	// Resolved pin drive
	output port_c_pkg::pin_drive_type drive_out
);

	logic [7:0] ovr_drive;
	logic [7:0] ovr_value;
	logic [7:0] ovr_hiz;

	// ****************************************************************
	// Peripheral overrides per pin
	// ****************************************************************
	always_comb begin
		ovr_drive = 8'h00;
		ovr_value = 8'h00;
		ovr_hiz = 8'h00;
		// First channel compare output on pin 2
		if (periph_in.ccp1_out_enable && !direction_in[`PIN_FIRST_CHANNEL]) begin
			ovr_drive[`PIN_FIRST_CHANNEL] = 1'b1;
			ovr_value[`PIN_FIRST_CHANNEL] = periph_in.ccp1_out;
		end
		// First PWM channel A beats port data
		if (periph_in.pwm1a_drive) begin
			ovr_drive[`PIN_FIRST_CHANNEL] = 1'b1;
			ovr_value[`PIN_FIRST_CHANNEL] = periph_in.pwm1a_value;
			ovr_hiz[`PIN_FIRST_CHANNEL] = periph_in.pwm1a_hiz;
		end
		// Second channel lands on pin 1 only when selected
		if (pin_select_in) begin
			if (periph_in.ccp2_out_enable && !direction_in[`PIN_OSC_IN]) begin
				ovr_drive[`PIN_OSC_IN] = 1'b1;
				ovr_value[`PIN_OSC_IN] = periph_in.ccp2_out;
			end
			if (periph_in.pwm2a_drive) begin
				ovr_drive[`PIN_OSC_IN] = 1'b1;
				ovr_value[`PIN_OSC_IN] = periph_in.pwm2a_value;
				ovr_hiz[`PIN_OSC_IN] = periph_in.pwm2a_hiz;
			end
		end
		// Serial modules on the upper pins
		ovr_drive[7:3] = periph_in.serial_drive;
		ovr_value[7:3] = periph_in.serial_value;
		ovr_hiz[7:3] = periph_in.serial_force_input;
		// Timer oscillator takes pins 0 and 1 from digital use
		if (periph_in.osc_enable) begin
			ovr_drive[1:0] = 2'b00;
			ovr_hiz[1:0] = 2'b11;
		end
	end

	// ****************************************************************
	// Final driver per pin
	// ****************************************************************
	genvar i;
	generate
		for (i = 0; i < `PORT_WIDTH; i = i + 1) begin : g_pin
			// Hiz wins, then override, then latch under direction
			assign drive_out.enable[i] = !ovr_hiz[i] && (ovr_drive[i] || !direction_in[i]);
			assign drive_out.value[i] = ovr_drive[i] ? ovr_value[i] : latch_in[i];
		end
	endgenerate

endmodule : port_pin_mux
`default_nettype wire

// File: port_c_gpio.sv
// Function
// - Eight pins, each direction, latch, input
// - Direction one makes pin input, undriven
// - Direction zero drives latch onto pin
// - Latch register readable, returns latched values
// - Every reset leaves all pins inputs
// - Enabled peripherals may force direction
// - Direction reads return stored bits always
// - Timer oscillator disables digital pins 0,1
// - Config bit routes second channel pin
// - Compare output beats latch; input feeds capture
// - PWM channel A overrides, may tri-state
// - Pin 0 input clocks timer counters
// - Serial outputs on pins 3-7 override
`timescale 1ns/1ps
`default_nettype none
`include "port_c_cfg.svh"

module port_c_gpio (
	// Clock, reset, enable
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// External pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_out,
	// Peripheral side
	input wire port_c_pkg::periph_type periph_in,
	output port_c_pkg::periph_return_type periph_ret_out,
	output logic second_channel_pin_select_out
);

	// ****************************************************************
	// State and next state
	// ****************************************************************
	port_c_pkg::state_type r;
	port_c_pkg::state_type r_nxt;
	port_c_pkg::pin_drive_type drive;

	logic [3:0] hit;
	logic [7:0] pin_visible;
	logic [7:0] wr_byte;
	logic bus_access;

	// ****************************************************************
	// Register decode
	// ****************************************************************
	// One-hot hit vector: pin value, latch, direction, config
	function automatic logic [3:0] reg_hit(input logic [11:0] addr);
		logic [3:0] h;
		h = 4'h0;
		unique case (addr)
			`OFS_PORT_PIN_VALUE: h = 4'h1;
			`OFS_PORT_OUTPUT_LATCH: h = 4'h2;
			`OFS_PORT_DIRECTION: h = 4'h4;
			`OFS_PORT_CONFIG: h = 4'h8;
			default: h = 4'h0;
		endcase
		return h;
	endfunction : reg_hit

	// Read mux over the mapped registers
	function automatic logic [7:0] reg_read(input logic [3:0] h,
			input port_c_pkg::state_type s, input logic [7:0] pins);
		logic [7:0] d;
		d = 8'h00;
		if (h[0]) begin
			d = pins;
		end
		if (h[1]) begin
			d = s.latch;
		end
		if (h[2]) begin
			d = s.direction;
		end
		if (h[3]) begin
			d = s.config_bits;
		end
		return d;
	endfunction : reg_read

	// ****************************************************************
	// Pin multiplexer
	// ****************************************************************
	port_pin_mux port_pin_mux_inst (
		.latch_in(r.latch),
		.direction_in(r.direction),
		.pin_select_in(r.config_bits[`CFG_PIN_SELECT_BIT]),
		.periph_in(periph_in),
		.drive_out(drive)
	);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// Address hit, write byte, gated pin levels
	always_comb begin
		hit = reg_hit(paddr_in);
		wr_byte = pwdata_in[7:0];
		bus_access = psel_in && penable_in;
		pin_visible = r.pin_sample;
		// Oscillator pins read as zero while it runs
		if (periph_in.osc_enable) begin
			pin_visible[1:0] = 2'b00;
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		r_nxt = r;
		// Pins sampled each cycle, synchronous to the clock
		r_nxt.pin_sample = pin_in;
		// Pin drive registered so outputs leave flops
		r_nxt.drive = drive;
		// Bus sequencing: answer in the second access cycle
		unique case (r.bus_state)
			port_c_pkg::bus_idle: begin
				r_nxt.pready = 1'b0;
				r_nxt.pslverr = 1'b0;
				if (bus_access) begin
					r_nxt.bus_state = port_c_pkg::bus_answer;
					r_nxt.pready = 1'b1;
					r_nxt.pslverr = (hit == 4'h0);
					r_nxt.prdata = 32'h0000_0000;
					if (!pwrite_in) begin
						r_nxt.prdata = {24'h00_0000, reg_read(hit, r, pin_visible)};
					end
				end
			end
			port_c_pkg::bus_answer: begin
				// Write lands on the edge where pready is seen
				r_nxt.bus_state = port_c_pkg::bus_idle;
				r_nxt.pready = 1'b0;
				r_nxt.pslverr = 1'b0;
				if (bus_access && pwrite_in) begin
					if (hit[0] || hit[1]) begin
						r_nxt.latch = wr_byte;
					end
					if (hit[2]) begin
						r_nxt.direction = wr_byte;
					end
					if (hit[3]) begin
						r_nxt.config_bits = {7'h00, wr_byte[`CFG_PIN_SELECT_BIT]};
					end
				end
			end
			// Unused codes fall back to idle
			default: begin
				r_nxt.bus_state = port_c_pkg::bus_idle;
				r_nxt.pready = 1'b0;
				r_nxt.pslverr = 1'b0;
			end
		endcase
		// Capture inputs only when the pin is an input
		r_nxt.ret.ccp1_capture = r.direction[`PIN_FIRST_CHANNEL]
			&& r.pin_sample[`PIN_FIRST_CHANNEL];
		r_nxt.ret.ccp2_capture = r.config_bits[`CFG_PIN_SELECT_BIT]
			&& r.direction[`PIN_OSC_IN] && pin_visible[`PIN_OSC_IN];
		// Pin 0 as input feeds the counter clock
		r_nxt.ret.count_clock = r.direction[`PIN_OSC_OUT]
			&& pin_visible[`PIN_OSC_OUT];
		// Serial inputs see the raw upper pins
		r_nxt.ret.serial_input = r.pin_sample[7:3];
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// All pins come up as inputs on reset
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			r.bus_state <= port_c_pkg::bus_idle;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
			r.prdata <= 32'h0000_0000;
			r.latch <= `RST_PORT_OUTPUT_LATCH;
			r.direction <= `RST_PORT_DIRECTION;
			r.config_bits <= `RST_PORT_CONFIG;
			r.pin_sample <= 8'h00;
			r.drive.value <= 8'h00;
			r.drive.enable <= `RST_PIN_OE;
			r.ret <= '0;
		end else if (clk_en_in) begin
			r <= r_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every output taken straight from the state flops
	assign prdata_out = r.prdata;
	assign pready_out = r.pready;
	assign pslverr_out = r.pslverr;
	assign pin_out = r.drive.value;
	assign pin_oe_out = r.drive.enable;
	assign periph_ret_out = r.ret;
	assign second_channel_pin_select_out = r.config_bits[`CFG_PIN_SELECT_BIT];

endmodule : port_c_gpio
`default_nettype wire

// File: port_c_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module port_c_assertions (
	// Clock, reset
	input wire logic mclk_in,
	input wire logic reset_n_in,
	// Bus
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	// Pins, peripherals
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_out,
	input wire port_c_pkg::periph_type periph_in,
	input wire port_c_pkg::periph_return_type periph_ret_out,
	input wire logic second_channel_pin_select_out
);
	// ****************
	// Port checks
	// ****************
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	// Bus steps and routed pwm
	sequence s_setup; psel_in && !penable_in; endsequence
	sequence s_wait; !pready_out ##1 pready_out; endsequence
	sequence s_pwm;
		$past(periph_in.pwm2a_drive) && $past(second_channel_pin_select_out)
			&& !$past(periph_in.osc_enable);
	endsequence
	property p_wait; s_setup ##1 penable_in |-> s_wait; endproperty
	a_wait: assert property (p_wait) else $error("bus wait wrong");
	property p_osc; $past(periph_in.osc_enable) |-> pin_oe_out[1:0] == 2'h0; endproperty
	a_osc: assert property (p_osc) else $error("osc pins driven");
	property p_force;
		(pin_oe_out[7:3] & $past(periph_in.serial_force_input)) == 5'h00;
	endproperty
	a_force: assert property (p_force) else $error("forced pin driven");
	property p_sdrv;
		($past(periph_in.serial_drive) & ~$past(periph_in.serial_force_input)
			& ~pin_oe_out[7:3]) == 5'h00;
	endproperty
	a_sdrv: assert property (p_sdrv) else $error("serial pin undriven");
	property p_pwm;
		s_pwm ##0 !$past(periph_in.pwm2a_hiz)
			|-> pin_oe_out[1] && pin_out[1] == $past(periph_in.pwm2a_value);
	endproperty
	a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
	property p_hiz; s_pwm ##0 $past(periph_in.pwm2a_hiz) |-> !pin_oe_out[1]; endproperty
	a_hiz: assert property (p_hiz) else $error("pwm pin not released");
	property p_cap; periph_ret_out.ccp1_capture |-> $past(pin_in[2], 2); endproperty
	a_cap: assert property (p_cap) else $error("capture without pin");
	property p_cnt; periph_ret_out.count_clock |-> $past(pin_in[0], 2); endproperty
	a_cnt: assert property (p_cnt) else $error("count clock without pin");
endmodule : port_c_assertions
bind port_c_gpio port_c_assertions port_c_assertions_inst (
	.mclk_in(mclk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pready_out(pready_out), .pin_in(pin_in),
	.pin_out(pin_out), .pin_oe_out(pin_oe_out), .periph_in(periph_in),
	.periph_ret_out(periph_ret_out),
	.second_channel_pin_select_out(second_channel_pin_select_out)
);
`default_nettype wire

// File: port_c_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module port_c_pins_model (
	// Clock
	input wire logic mclk_in,
	// Drivers
	input wire logic [7:0] pin_out_in,
	input wire logic [7:0] pin_oe_in,
	input wire logic [7:0] ext_val_in,
	input wire logic [7:0] ext_oe_in,
	// Wire levels
	output logic [7:0] level_out
);
	logic [7:0] float_r = 8'h55;
	// Undriven pins wander
	always_ff @(posedge mclk_in) float_r <= ~float_r;
	// Design driver first, then outside, else floating
	assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_oe_in & ext_val_in)
		| (~pin_oe_in & ~ext_oe_in & float_r);
endmodule : port_c_pins_model
`default_nettype wire

// File: port_c_gpio_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "port_c_cfg.svh"
module port_c_gpio_bench;
	localparam logic [11:0] a_pin = `OFS_PORT_PIN_VALUE;
	localparam logic [11:0] a_lat = `OFS_PORT_OUTPUT_LATCH;
	localparam logic [11:0] a_dir = `OFS_PORT_DIRECTION;
	localparam logic [11:0] a_cfg = `OFS_PORT_CONFIG;
	logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, sel, err;
	logic cken = 1'b1;
	logic [7:0] lvl, pout, poe, ext_v = 8'h00, ext_oe = 8'h00;
	port_c_pkg::periph_type pr = '0;
	port_c_pkg::periph_return_type ret;
	int fails = 0, tests_run = 0;
	// ****************
	// Design and pins
	// ****************
	port_c_gpio port_c_gpio_inst (.mclk_in(mclk), .reset_n_in(reset_n), .clk_en_in(cken),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
		.pin_in(lvl), .pin_out(pout), .pin_oe_out(poe), .periph_in(pr),
		.periph_ret_out(ret), .second_channel_pin_select_out(sel));
	port_c_pins_model port_c_pins_model_inst (.mclk_in(mclk), .pin_out_in(pout),
		.pin_oe_in(poe), .ext_val_in(ext_v), .ext_oe_in(ext_oe), .level_out(lvl));
	// Clock
	always #2 mclk = ~mclk;
	// Compare and bus tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		// Hold the request until pready is seen at a rising edge
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			fails++;
			stop_test;
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rdat, {24'h0, e});
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask : settle
	task automatic stop_test;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// ****************
	// Scenarios
	// ****************
	task automatic t_out;
		chk(poe, 8'h00);
		rd(a_dir, 8'hff);
		wr(a_dir, 8'h00);
		wr(a_lat, 8'ha5);
		settle;
		chk({poe, pout}, 16'hffa5);
		rd(a_pin, 8'ha5);
		@(posedge mclk);
		pr.serial_drive <= 5'h10;
		settle;
		chk(pout, 8'h25);
		rd(a_lat, 8'ha5);
		pr.serial_drive <= 5'h00;
		wr(a_pin, 8'h3c);
		rd(a_lat, 8'h3c);
		cken <= 1'b0;
		pr.serial_drive <= 5'h01;
		settle;
		chk(pout, 8'h3c);
		@(posedge mclk);
		cken <= 1'b1;
		settle;
		chk(pout, 8'h34);
		@(posedge mclk);
		pr.serial_drive <= 5'h00;
	endtask : t_out
	task automatic t_in;
		wr(a_dir, 8'hf3);
		ext_v <= 8'h93;
		ext_oe <= 8'hf3;
		settle;
		chk(poe, 8'h0c);
		rd(a_pin, 8'h9f);
		chk(ret.count_clock, 1'b1);
		chk(ret.ccp2_capture, 1'b1);
		chk(ret.serial_input, 5'h13);
		pr.serial_force_input <= 5'h01;
		settle;
		chk(poe, 8'h04);
		rd(a_dir, 8'hf3);
	endtask : t_in
	task automatic t_osc;
		pr.serial_force_input <= 5'h00;
		pr.osc_enable <= 1'b1;
		settle;
		rd(a_pin, 8'h9c);
		chk(ret.count_clock, 1'b0);
		chk(ret.ccp2_capture, 1'b0);
		ext_oe <= 8'h00;
		wr(a_dir, 8'h00);
		settle;
		chk(poe, 8'hfc);
	endtask : t_osc
	task automatic t_pwm;
		@(posedge mclk);
		pr.osc_enable <= 1'b0;
		pr.pwm2a_drive <= 1'b1;
		pr.pwm2a_value <= 1'b1;
		settle;
		chk(pout, 8'h3e);
		wr(a_cfg, 8'h00);
		settle;
		chk({sel, pout}, 9'h03c);
		wr(a_cfg, 8'h01);
		pr.pwm2a_hiz <= 1'b1;
		pr.ccp1_out_enable <= 1'b1;
		settle;
		chk({poe, pout[2]}, 9'h1fa);
		wr(a_dir, 8'h04);
		ext_v <= 8'h04;
		ext_oe <= 8'h04;
		settle;
		chk(ret.ccp1_capture, 1'b1);
		apb(1'b0, 12'h010, 8'h00);
		chk(err, 1'b1);
		chk(rdat, 32'h0000_0000);
		ext_oe <= 8'h00;
		pr.pwm1a_drive <= 1'b1;
		pr.pwm1a_value <= 1'b1;
		pr.pwm2a_drive <= 1'b0;
		pr.ccp2_out_enable <= 1'b1;
		pr.ccp2_out <= 1'b1;
		settle;
		chk({poe[2:1], pout[2:1]}, 4'hf);
	endtask : t_pwm
	task automatic t_rst;
		@(posedge mclk);
		reset_n <= 1'b0;
		settle;
		chk({poe, pout, sel}, 17'h00001);
		@(posedge mclk);
		reset_n <= 1'b1;
		rd(a_dir, 8'hff);
	endtask : t_rst
	// Main sequence
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		t_out;
		t_in;
		t_osc;
		t_pwm;
		t_rst;
		stop_test;
	end
	// Watchdog
	initial begin
		#100000;
		fails++;
		stop_test;
	end
endmodule : port_c_gpio_bench
`default_nettype wire
